// File: hw/irq_mask_stack.sv
// Interrupt masking, pending capture and global enable nesting stack.
// Assumes the sequencer pulses instr_step once per instruction and ack
// only while irq_valid is high; vector fetch and PC stacking live elsewhere.
//
// What this block does
// R1 - Cause mask register is 16 bits; 0 enables, 1 disables.
// R2 - Cause mask register resets to 0xF000.
// R3 - Top three mask bits are shared storage with the stack top.
// R4 - Bits 0..9 disable pins a-d, serial1 rx/tx, serial2 rx/tx, upstream rx/tx.
// R5 - Acknowledge shifts stack right one bit, then sets current global flag.
// R6 - Return shifts stack left, dropping current flag, loading bottom with 1.
// R7 - Stack holds fifteen nested acknowledges without losing saved state.
// R8 - Stack register resets to all ones.
// R9 - Stack write affects acceptance only three instructions later.
// R10 - Mask write keeps old global flag for two following instructions.
// R11 - Acknowledge and return leave per-cause flags unchanged.
// R12 - Reserved mask bits ignore writes.
// R13 - Loop bit reads 0 inside a hardware loop, else 1.
// R14 - Software sets current flag before rewriting older flags.
// R15 - Software disables globally before rewriting per-cause flags.
// R16 - Disabled requests stay pending until enables permit them.
// R17 - Serial and upstream causes fire on buffer completion events.
// R18 - Both registers read and write by register transfer.
// R19 - Accept only with current global flag 0 and cause flag 0.
// R20 - Pin requests raise on a synchronised falling edge.
// R21 - Each cause maps to vector 0x200 plus four words per slot.
// R22 - Lowest pending enabled cause wins; others stay pending.
`timescale 1ns/1ps
module irq_mask_stack (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire irq_mask_pkg::core_ctl_s ctl,
  input  wire logic                  loop_active,
  input  wire logic [3:0]            ext_pin_n,
  input  wire logic                  serial1_rx_done,
  input  wire logic                  serial1_tx_done,
  input  wire logic                  serial2_rx_done,
  input  wire logic                  serial2_tx_done,
  input  wire logic                  upstream_rx_done,
  input  wire logic                  upstream_tx_done,
  output logic [15:0]                cause_and_global_mask,
  output logic [15:0]                global_enable_stack,
  output logic                       irq_valid,
  output logic [10:0]                irq_vector,
  output logic [9:0]                 pending_out
);
  logic [15:0] stack_reg;
  logic [15:0] stack_next;
  logic [9:0]  cause_reg;
  logic [9:0]  pend_reg;
  logic [9:0]  pend_next;
  logic [9:0]  events;
  logic [3:0]  pin_s1_reg;
  logic [3:0]  pin_s2_reg;
  logic [3:0]  pin_s3_reg;
  logic [3:0]  pin_lvl_reg;
  logic [1:0]  mask_hold_reg;
  logic        mask_old_reg;
  logic [1:0]  stk_hold_reg;
  logic        stk_old_reg;
  logic        gate_now;
  logic [9:0]  eligible;
  logic [9:0]  grant;
  logic        loop_s1_reg;
  logic        loop_s2_reg;
  irq_mask_pkg::acc_state_e state_reg;

  function automatic logic [9:0] lowest_one(input logic [9:0] v);
    lowest_one = v & (~v + 10'h001);
  endfunction

  function automatic logic [10:0] vector_of(input logic [9:0] onehot);
    logic [10:0] idx;
    idx = 11'h000;
    for (int i = 0; i < irq_mask_pkg::NUM_CAUSES; i++) begin
      if (onehot[i]) begin
        idx = 11'(i);
      end
    end
    vector_of = irq_mask_pkg::VEC_BASE + irq_mask_pkg::VEC_FIRST_CAUSE
                + (idx << irq_mask_pkg::VEC_STRIDE_LOG2);
  endfunction

  // Pin synchroniser, three stages, change on second/third agreement
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_s1_reg  <= 4'hf;
      pin_s2_reg  <= 4'hf;
      pin_s3_reg  <= 4'hf;
      pin_lvl_reg <= 4'hf;
    end else begin
      pin_s1_reg <= ext_pin_n;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      for (int i = 0; i < 4; i++) begin
        if (pin_s2_reg[i] == pin_s3_reg[i]) begin
          pin_lvl_reg[i] <= pin_s3_reg[i];
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      loop_s1_reg <= 1'b0;
      loop_s2_reg <= 1'b0;
    end else begin
      loop_s1_reg <= loop_active;
      loop_s2_reg <= loop_s1_reg;
    end
  end

  always_comb begin
    events[3:0] = pin_lvl_reg & ~((pin_s2_reg == pin_s3_reg) ? pin_s3_reg : pin_lvl_reg); // [R20]
    events[4]   = serial1_rx_done; // [R17]
    events[5]   = serial1_tx_done;
    events[6]   = serial2_rx_done;
    events[7]   = serial2_tx_done;
    events[irq_mask_pkg::CAUSE_UP_RX] = upstream_rx_done; // [R17]
    events[irq_mask_pkg::CAUSE_UP_TX] = upstream_tx_done;
  end

  // Global flag seen by acceptance, frozen for a few instructions after writes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mask_hold_reg <= 2'h0;
      mask_old_reg  <= 1'b1;
      stk_hold_reg  <= 2'h0;
      stk_old_reg   <= 1'b1;
    end else begin
      if (ctl.write_mask) begin
        mask_hold_reg <= 2'(irq_mask_pkg::MASK_WR_DELAY); // [R10]
        mask_old_reg  <= (mask_hold_reg != 2'h0) ? mask_old_reg : stack_reg[15];
      end else if (ctl.instr_step && mask_hold_reg != 2'h0) begin
        mask_hold_reg <= mask_hold_reg - 2'h1;
      end
      if (ctl.write_stack) begin
        stk_hold_reg <= 2'(irq_mask_pkg::STACK_WR_DELAY); // [R9]
        stk_old_reg  <= (stk_hold_reg != 2'h0) ? stk_old_reg : stack_reg[15];
      end else if (ctl.instr_step && stk_hold_reg != 2'h0) begin
        stk_hold_reg <= stk_hold_reg - 2'h1;
      end
    end
  end

  always_comb begin
    if (stk_hold_reg != 2'h0) begin
      gate_now = stk_old_reg; // [R9]
    end else if (mask_hold_reg != 2'h0) begin
      gate_now = mask_old_reg; // [R10]
    end else begin
      gate_now = stack_reg[irq_mask_pkg::BIT_NOW];
    end
  end

  // Stack register; its top three bits are the mask register's top bits
  always_comb begin
    stack_next = stack_reg;
    if (ctl.ack && state_reg == irq_mask_pkg::ACC_OFFER) begin
      stack_next = {1'b1, stack_reg[15:1]}; // [R5] [R7]
    end else if (ctl.irq_return_op) begin
      stack_next = {stack_reg[14:0], 1'b1}; // [R6] [R7]
    end else if (ctl.write_stack) begin
      stack_next = ctl.wdata; // [R18]
    end else if (ctl.write_mask) begin
      stack_next = {ctl.wdata[15:13], stack_reg[12:0]}; // [R3]
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stack_reg <= irq_mask_pkg::STACK_RST; // [R8]
    end else begin
      stack_reg <= stack_next;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cause_reg <= irq_mask_pkg::CAUSE_MASK_RST[9:0]; // [R2]
    end else if (ctl.write_mask) begin
      cause_reg <= ctl.wdata[9:0] & irq_mask_pkg::CAUSE_WR_MASK[9:0]; // [R12] [R11] [R4]
    end
  end

  assign eligible = (gate_now == 1'b0) ? (pend_reg & ~cause_reg) : 10'h000; // [R19]
  assign grant    = lowest_one(eligible); // [R22]

  // Pending latch: a new event beats a same-cycle acknowledge clear
  always_comb begin
    pend_next = pend_reg;
    if (ctl.ack && state_reg == irq_mask_pkg::ACC_OFFER) begin
      pend_next = pend_next & ~pending_sel_mask();
    end
    pend_next = pend_next | events; // [R16]
  end

  function automatic logic [9:0] pending_sel_mask();
    pending_sel_mask = 10'h000;
    for (int i = 0; i < irq_mask_pkg::NUM_CAUSES; i++) begin
      if (irq_vector == vector_of(10'(1 << i))) begin
        pending_sel_mask[i] = 1'b1;
      end
    end
  endfunction

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pend_reg <= 10'h000;
    end else begin
      pend_reg <= pend_next;
    end
  end

  // Offer to sequencer: hold the offer stable until acknowledged or no cause is eligible
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg  <= irq_mask_pkg::ACC_IDLE;
      irq_valid  <= 1'b0;
      irq_vector <= irq_mask_pkg::VEC_BASE;
    end else begin
      case (state_reg)
        irq_mask_pkg::ACC_IDLE: begin
          if (grant != 10'h000 && !ctl.ack) begin
            state_reg  <= irq_mask_pkg::ACC_OFFER;
            irq_valid  <= 1'b1;
            irq_vector <= vector_of(grant); // [R21]
          end
        end
        irq_mask_pkg::ACC_OFFER: begin
          if (ctl.ack || eligible == 10'h000) begin
            state_reg <= irq_mask_pkg::ACC_IDLE;
            irq_valid <= 1'b0;
          end
        end
        default: begin
          state_reg <= irq_mask_pkg::ACC_IDLE;
          irq_valid <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cause_and_global_mask <= irq_mask_pkg::CAUSE_MASK_RST;
      global_enable_stack   <= irq_mask_pkg::STACK_RST;
      pending_out           <= 10'h000;
    end else begin
      cause_and_global_mask <= {stack_next[15:13], ~loop_s2_reg, 2'b00,
                                (ctl.write_mask ? ctl.wdata[9:0] : cause_reg)}; // [R3] [R13]
      global_enable_stack   <= stack_next;
      pending_out           <= pend_next;
    end
  end

  stack_ack_a: assert property (@(posedge clock) disable iff (!rst_n)
    (ctl.ack && state_reg == irq_mask_pkg::ACC_OFFER)
    |=> stack_reg == {1'b1, $past(stack_reg[15:1])})
    else $error("stack not pushed on acknowledge"); // [R5]
  stack_ret_a: assert property (@(posedge clock) disable iff (!rst_n)
    (ctl.irq_return_op && !(ctl.ack && state_reg == irq_mask_pkg::ACC_OFFER))
    |=> stack_reg == {$past(stack_reg[14:0]), 1'b1})
    else $error("stack not popped on return"); // [R6]
  cause_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!ctl.write_mask) |=> $stable(cause_reg))
    else $error("cause flags changed without write"); // [R11]
  shared_top_a: assert property (@(posedge clock) disable iff (!rst_n)
    cause_and_global_mask[15:13] == global_enable_stack[15:13])
    else $error("shared global bits differ"); // [R3]
  accept_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
    (grant != 10'h000) |-> (gate_now == 1'b0 && (grant & cause_reg) == 10'h000))
    else $error("grant while disabled"); // [R19]
  stk_delay_a: assert property (@(posedge clock) disable iff (!rst_n)
    ctl.write_stack |=> stk_hold_reg == 2'h3)
    else $error("stack write delay wrong"); // [R9]
  mask_delay_a: assert property (@(posedge clock) disable iff (!rst_n)
    (ctl.write_mask && !ctl.write_stack && stk_hold_reg == 2'h0 && mask_hold_reg == 2'h0)
    |=> (mask_hold_reg == 2'h2 && gate_now == $past(stack_reg[15])))
    else $error("mask write delay wrong"); // [R10]
  pend_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
    (events != 10'h000) |=> ((pend_reg & $past(events)) == $past(events)))
    else $error("event lost"); // [R16]
  lowest_a: assert property (@(posedge clock) disable iff (!rst_n)
    (eligible != 10'h000) |-> (((grant - 10'h001) & eligible) == 10'h000 && grant != 10'h000))
    else $error("not lowest cause"); // [R22]
endmodule

// File: hw/irq_mask_pkg.sv
// Package for the interrupt mask and nesting stack block.
// Assumes a single core clock; no imports are used by clients.
package irq_mask_pkg;
  localparam int          NUM_CAUSES      = 10;
  localparam logic [15:0] CAUSE_MASK_RST  = 16'hf000;
  localparam logic [15:0] STACK_RST       = 16'hffff;
  localparam int          BIT_NOW         = 15;
  localparam int          BIT_PREV        = 14;
  localparam int          BIT_OLDER       = 13;
  localparam int          BIT_LOOP        = 12;
  localparam logic [15:0] CAUSE_WR_MASK   = 16'h03ff;
  localparam int          STACK_WR_DELAY  = 3;
  localparam int          MASK_WR_DELAY   = 2;
  localparam logic [10:0] VEC_BASE        = 11'h200;
  localparam logic [10:0] VEC_FIRST_CAUSE = 11'h010;
  localparam int          VEC_STRIDE_LOG2 = 2;
  localparam int          CAUSE_PIN_A     = 0;
  localparam int          CAUSE_UP_RX     = 8;
  localparam int          CAUSE_UP_TX     = 9;

  typedef struct packed {
    logic       write_mask;
    logic       write_stack;
    logic [15:0] wdata;
    logic       instr_step;
    logic       ack;
    logic       irq_return_op;
  } core_ctl_s;

  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_OFFER = 2'b01
  } acc_state_e;
endpackage

// File: sim/seq_model.sv
// Sequencer model: takes offered interrupts and later returns from them.
// Assumes ack is only raised while irq_valid is high, one cycle at a time.
`timescale 1ns/1ps
module seq_model (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic irq_valid,
  input  wire logic slow,
  output logic      ack,
  output logic      ret_op
);
  initial begin
    ack = 1'b0;
    ret_op = 1'b0;
    forever begin
      @(posedge clock);
      #1;
      if (rst_n && irq_valid) begin
        repeat (slow ? 3 : 0) @(posedge clock);
        ack = 1'b1;
        @(posedge clock);
        #1 ack = 1'b0;
        repeat (6) @(posedge clock);
        #1 ret_op = 1'b1;
        @(posedge clock);
        #1 ret_op = 1'b0;
      end
    end
  end
endmodule

// File: sim/tb.sv
// Testbench for the interrupt mask and nesting stack.
// Assumes one instruction completes every cycle once reset is released.
`timescale 1ns/1ps
module tb;
  logic                    clock, rst_n, loop_active, slow, ack, ret_op, irq_valid;
  logic                    chk_ack, chk_ret;
  logic [3:0]              ext_pin_n;
  logic [5:0]              done;
  irq_mask_pkg::core_ctl_s drv, ctl;
  logic [15:0]             mask_r, stack_r, prev_stack, prev_mask;
  logic [10:0]             irq_vector;
  logic [9:0]              pending_out;
  logic [15:0]             exp_q[$];
  int                      bad_count, tests_run, cycles, seed, idx;

  always_comb begin
    ctl = drv;
    ctl.ack = ack;
    ctl.irq_return_op = ret_op;
  end

  irq_mask_stack i_dut (.clock(clock), .rst_n(rst_n), .ctl(ctl), .loop_active(loop_active),
    .ext_pin_n(ext_pin_n), .serial1_rx_done(done[0]), .serial1_tx_done(done[1]),
    .serial2_rx_done(done[2]), .serial2_tx_done(done[3]), .upstream_rx_done(done[4]),
    .upstream_tx_done(done[5]), .cause_and_global_mask(mask_r),
    .global_enable_stack(stack_r), .irq_valid(irq_valid), .irq_vector(irq_vector),
    .pending_out(pending_out));

  seq_model i_seq (.clock(clock), .rst_n(rst_n), .irq_valid(irq_valid), .slow(slow),
    .ack(ack), .ret_op(ret_op));

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks=%0d errors=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Raise a set of causes at once; vectors noted lowest index first
  task automatic fire(input logic [9:0] set);
    for (int i = 0; i < 10; i++)
      if (set[i]) exp_q.push_back(16'h0210 + 16'(4 * i));
    @(posedge clock);
    #1 ext_pin_n = ~set[3:0];
    done = set[9:4];
    @(posedge clock);
    #1 done = 6'h00;
    repeat (4) @(posedge clock);
    #1 ext_pin_n = 4'hf;
  endtask

  task automatic wr(input logic to_stack, input logic [15:0] d);
    @(posedge clock);
    #1 drv.write_stack = to_stack;
    drv.write_mask = !to_stack;
    drv.wdata = d;
    @(posedge clock);
    #1 drv.write_stack = 1'b0;
    drv.write_mask = 1'b0;
  endtask

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Result watcher: vector on each take, stack after take and return
  always @(posedge clock) begin
    cycles++;
    if (cycles > 3000) begin
      bad_count++;
      results();
    end
    if (chk_ack) cmp(stack_r, {1'b1, prev_stack[15:1]});
    if (chk_ack) cmp({stack_r[15:13], mask_r[9:0]}, {mask_r[15:13], prev_mask[9:0]});
    if (chk_ret) cmp(stack_r, {prev_stack[14:0], 1'b1});
    chk_ack = irq_valid && ack;
    chk_ret = ret_op;
    prev_stack = stack_r;
    prev_mask = mask_r;
    if (chk_ack) cmp({5'h00, irq_vector}, exp_q.size() ? exp_q.pop_front() : 16'hffff);
  end

  initial begin
    seed = 20;
    {rst_n, loop_active, slow, chk_ack, chk_ret, done} = '0;
    {bad_count, tests_run, cycles} = '0;
    ext_pin_n = 4'hf;
    drv = '0;
    repeat (12) @(posedge clock);
    #1 rst_n = 1'b1;
    drv.instr_step = 1'b1;
    cmp(mask_r, 16'hf000);
    cmp(stack_r, 16'hffff);
    fire(10'h100);
    cmp({pending_out, 5'h00, irq_valid}, 16'h4000);
    wr(1'b0, 16'hfc00);
    #1 cmp(mask_r, 16'hf000);
    loop_active = 1'b1;
    repeat (4) @(posedge clock);
    #1 cmp({15'h0000, mask_r[12]}, 16'h0000);
    loop_active = 1'b0;
    wr(1'b1, 16'h7fff);
    cmp({stack_r[14:0], irq_valid}, 16'hfffe);
    repeat (30) @(posedge clock);
    fire(10'h180);
    repeat (40) @(posedge clock);
    for (int n = 0; n < 14; n++) begin
      idx = $random(seed);
      idx = (idx < 0 ? -idx : idx) % 10;
      slow = idx[0];
      fire(10'h001 << idx);
      repeat (20) @(posedge clock);
    end
    cmp(16'(exp_q.size()), 16'h0000);
    results();
  end
endmodule
